// ---- logic/dsc_stop_logic.v ----
// How it works
// - Report requested drive set, status bit 0 and bit 1 from selection bits.
// - With one drive set configured, the selected-set status reads zero.
// - On/ramp-stop command comes from a selectable source, control word bit 0.
// - After the on source is reassigned, only a fresh edge switches on.
// - With on/ramp-stop low, either jog input may still run the motor.
// - On/ramp-stop low acknowledges and clears switching-on-inhibited.
// - Only the source that switched on can switch off; others are ignored.
// - Speed mode 20: ramp-stop brakes on ramp, then pulses off, inhibited.
// - Torque mode 22: ramp-stop suppresses pulses at once, no ramp.
// - Torque switch active: ramp-stop does not brake; pulses off at standstill.
// - A 0 to 1 edge on on/ramp-stop switches the drive on.
// - No-coast-stop is the AND of two selectable sources, control word bit 1.
// - Either coast source low: pulses off now, inhibited; both high allows enable.
// - No-quick-stop is the AND of two selectable sources, control word bit 2.
// - Either quick source low: brake on quick ramp, then pulses off, inhibited.
// - Torque switch active: quick stop does not brake; pulses off at standstill.
// - PC master control bypasses on source and first coast and quick sources.
// - PC master control leaves second coast and quick sources effective.
// - Every source selection is held per command set; the effective set is used.
// - Master control flag reads 1 when the PC holds control, else 0.
// - Master control overrides only control word 1, nothing else.
`include "dsc_consts.vh"

module dsc_stop_logic
(
   input wire core_clk_in,
   input wire reset_in,
   input wire [15:0] control_word_in,
   input wire [5:0] digital_in,
   input wire pc_master_in,
   input wire [2:0] pc_control_word_in,
   input wire [1:0] command_set_select_in,
   input wire [2:0] command_set_count_in,
   input wire [2:0] drive_set_count_in,
   input wire [15:0] on_ramp_stop_source_in,
   input wire [15:0] coast_stop_source_a_in,
   input wire [15:0] coast_stop_source_b_in,
   input wire [15:0] quick_stop_source_a_in,
   input wire [15:0] quick_stop_source_b_in,
   input wire [15:0] jog_source_one_in,
   input wire [15:0] jog_source_two_in,
   input wire [15:0] drive_set_select_bit0_source_in,
   input wire [15:0] drive_set_select_bit1_source_in,
   input wire [4:0] control_mode_select_in,
   input wire torque_mode_switch_in,
   input wire [15:0] speed_abs_in,
   input wire [15:0] standstill_threshold_in,
   input wire [15:0] standstill_monitor_time_in,
   output reg pulse_enable_out,
   output reg ramp_stop_brake_out,
   output reg quick_stop_brake_out,
   output reg switch_on_inhibited_out,
   output reg jog_active_out,
   output reg master_control_flag_out,
   output reg [1:0] selected_drive_set_status_out,
   output reg [1:0] effective_drive_set_display_out,
   output reg [1:0] effective_command_set_display_out
);

   // ----------------------------------------
   // Digital input synchroniser and filter
   // ----------------------------------------
   reg [5:0] di_s1_reg;
   reg [5:0] di_s2_reg;
   reg [5:0] di_s3_reg;
   reg [5:0] di_filt_reg;
   wire [5:0] di_filt_next;

   // A bit moves only once stages two and three agree
   assign di_filt_next = (di_s2_reg & di_s3_reg) | (di_filt_reg & (di_s2_reg ^ di_s3_reg));

   always @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         di_s1_reg <= 6'h00;
         di_s2_reg <= 6'h00;
         di_s3_reg <= 6'h00;
         di_filt_reg <= 6'h00;
      end
      else
      begin
         di_s1_reg <= digital_in;
         di_s2_reg <= di_s1_reg;
         di_s3_reg <= di_s2_reg;
         di_filt_reg <= di_filt_next;
      end
   end

   // ----------------------------------------
   // Effective command set
   // ----------------------------------------
   wire [1:0] cds_eff;
   // An unconfigured set falls back to set zero rather than reading stale selections
   assign cds_eff = ({1'b0, command_set_select_in} < command_set_count_in) ?
                    command_set_select_in : `DSC_RST_SET;

   // ----------------------------------------
   // Source selection per command
   // ----------------------------------------
   wire [15:0] pool;
   wire [16*`DSC_CMD_N-1:0] sel_all;
   wire [`DSC_CMD_N-1:0] cmd_sig;
   wire [`DSC_SEL_W*`DSC_CMD_N-1:0] sel_now;

   // Pins reach the pool only through the agreed filter; a raw pin here would be metastable
   assign pool = {di_filt_reg, control_word_in[7:0], 1'b1, 1'b0};
   assign sel_all = {drive_set_select_bit1_source_in, drive_set_select_bit0_source_in,
                     jog_source_two_in, jog_source_one_in,
                     quick_stop_source_b_in, quick_stop_source_a_in,
                     coast_stop_source_b_in, coast_stop_source_a_in,
                     on_ramp_stop_source_in};

   genvar gi;
   generate
      for (gi = 0; gi < `DSC_CMD_N; gi = gi + 1)
      begin : g_src
         wire [`DSC_SEL_W-1:0] sel;
         assign sel = sel_all[16*gi + `DSC_SEL_W*cds_eff +: `DSC_SEL_W];
         assign sel_now[`DSC_SEL_W*gi +: `DSC_SEL_W] = sel;
         assign cmd_sig[gi] = pool[sel];
      end
   endgenerate

   // ----------------------------------------
   // Command forming and master control
   // ----------------------------------------
   wire on_eff;
   wire coast_a;
   wire quick_a;
   wire coast_ok;
   wire quick_ok;
   wire jog1;
   wire jog2;

   // PC path replaces only control word 1 bits; the set selection stays local
   assign on_eff = pc_master_in ? pc_control_word_in[`DSC_CW_ON_BIT] :
                   cmd_sig[`DSC_CMD_ON];
   assign coast_a = pc_master_in ? pc_control_word_in[`DSC_CW_COAST_BIT] :
                    cmd_sig[`DSC_CMD_COAST_A];
   assign quick_a = pc_master_in ? pc_control_word_in[`DSC_CW_QUICK_BIT] :
                    cmd_sig[`DSC_CMD_QUICK_A];
   assign coast_ok = coast_a & cmd_sig[`DSC_CMD_COAST_B];
   assign quick_ok = quick_a & cmd_sig[`DSC_CMD_QUICK_B];
   assign jog1 = cmd_sig[`DSC_CMD_JOG1];
   assign jog2 = cmd_sig[`DSC_CMD_JOG2];

   // ----------------------------------------
   // On edge detect with reassignment guard
   // ----------------------------------------
   reg on_prev_reg;
   reg pc_prev_reg;
   reg [`DSC_SEL_W-1:0] on_sel_prev_reg;
   reg [1:0] cds_prev_reg;
   wire reassigned;
   wire on_rise;

   // A new source that already sits high must not look like a switch-on
   assign reassigned = (on_sel_prev_reg != sel_now[`DSC_SEL_W-1:0]) ||
                       (cds_prev_reg != cds_eff) || (pc_prev_reg != pc_master_in);
   assign on_rise = on_eff & ~on_prev_reg & ~reassigned;

   always @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         on_prev_reg <= 1'b1;
         pc_prev_reg <= 1'b0;
         on_sel_prev_reg <= `DSC_SEL_ZERO;
         cds_prev_reg <= `DSC_RST_SET;
      end
      else
      begin
         on_prev_reg <= on_eff;
         pc_prev_reg <= pc_master_in;
         on_sel_prev_reg <= sel_now[`DSC_SEL_W-1:0];
         cds_prev_reg <= cds_eff;
      end
   end

   // ----------------------------------------
   // Standstill detection
   // ----------------------------------------
   reg [15:0] still_cnt_reg;
   reg [15:0] still_cnt_next;
   wire standstill;

   assign standstill = (speed_abs_in < standstill_threshold_in) &&
                       (still_cnt_reg >= standstill_monitor_time_in);

   always @*
   begin
      still_cnt_next = `DSC_RST_CNT;
      if (speed_abs_in < standstill_threshold_in)
      begin
         if (still_cnt_reg == 16'hffff)
            still_cnt_next = still_cnt_reg;
         else
            still_cnt_next = still_cnt_reg + 16'h0001;
      end
   end

   // ----------------------------------------
   // Stop sequencer
   // ----------------------------------------
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [1:0] owner_reg;
   reg [1:0] owner_next;
   reg owner_low;

   always @*
   begin
      case (owner_reg)
         `DSC_OWN_JOG1: owner_low = ~jog1;
         `DSC_OWN_JOG2: owner_low = ~jog2;
         default: owner_low = ~on_eff;
      endcase
   end

   // In the run state coast is tested first, then quick, then the owner's stop
   always @*
   begin
      state_next = state_reg;
      owner_next = owner_reg;
      case (state_reg)
         `DSC_ST_INHIBIT:
         begin
            if (coast_ok && quick_ok && !on_eff)
               state_next = `DSC_ST_READY;
         end
         `DSC_ST_READY:
         begin
            if (!coast_ok || !quick_ok)
               state_next = `DSC_ST_INHIBIT;
            else if (on_rise)
            begin
               state_next = `DSC_ST_RUN;
               owner_next = `DSC_OWN_ON;
            end
            else if (!on_eff && jog1)
            begin
               state_next = `DSC_ST_RUN;
               owner_next = `DSC_OWN_JOG1;
            end
            else if (!on_eff && jog2)
            begin
               state_next = `DSC_ST_RUN;
               owner_next = `DSC_OWN_JOG2;
            end
         end
         `DSC_ST_RUN:
         begin
            if (!coast_ok)
               state_next = `DSC_ST_INHIBIT;
            else if (!quick_ok)
               state_next = torque_mode_switch_in ? `DSC_ST_WAIT : `DSC_ST_QUICK;
            else if (owner_low)
            begin
               // Only the owner's signal is looked at here
               if (torque_mode_switch_in)
                  state_next = `DSC_ST_WAIT;
               else if (control_mode_select_in == `DSC_MODE_TORQUE)
                  state_next = `DSC_ST_INHIBIT;
               else
                  state_next = `DSC_ST_RAMP;
            end
         end
         `DSC_ST_RAMP:
         begin
            if (!coast_ok)
               state_next = `DSC_ST_INHIBIT;
            else if (!quick_ok)
               state_next = torque_mode_switch_in ? `DSC_ST_WAIT : `DSC_ST_QUICK;
            else if (standstill)
               state_next = `DSC_ST_INHIBIT;
         end
         `DSC_ST_QUICK:
         begin
            if (!coast_ok)
               state_next = `DSC_ST_INHIBIT;
            else if (standstill)
               state_next = `DSC_ST_INHIBIT;
         end
         `DSC_ST_WAIT:
         begin
            if (!coast_ok)
               state_next = `DSC_ST_INHIBIT;
            else if (standstill)
               state_next = `DSC_ST_INHIBIT;
         end
         default:
            state_next = `DSC_ST_INHIBIT;
      endcase
   end

   // ----------------------------------------
   // Drive set selection
   // ----------------------------------------
   wire [1:0] dds_sel;
   wire [1:0] dds_status;

   assign dds_sel = {cmd_sig[`DSC_CMD_DDS1], cmd_sig[`DSC_CMD_DDS0]};
   assign dds_status = (drive_set_count_in <= 3'h1) ? 2'h0 : dds_sel;

   // ----------------------------------------
   // Registers and registered outputs
   // ----------------------------------------
   always @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         state_reg <= `DSC_RST_STATE;
         owner_reg <= `DSC_RST_OWNER;
         still_cnt_reg <= `DSC_RST_CNT;
         pulse_enable_out <= 1'b0;
         ramp_stop_brake_out <= 1'b0;
         quick_stop_brake_out <= 1'b0;
         switch_on_inhibited_out <= 1'b1;
         jog_active_out <= 1'b0;
         master_control_flag_out <= 1'b0;
         selected_drive_set_status_out <= `DSC_RST_SET;
         effective_drive_set_display_out <= `DSC_RST_SET;
         effective_command_set_display_out <= `DSC_RST_SET;
      end
      else
      begin
         state_reg <= state_next;
         owner_reg <= owner_next;
         still_cnt_reg <= still_cnt_next;
         pulse_enable_out <= (state_next != `DSC_ST_INHIBIT) && (state_next != `DSC_ST_READY);
         ramp_stop_brake_out <= (state_next == `DSC_ST_RAMP);
         quick_stop_brake_out <= (state_next == `DSC_ST_QUICK);
         switch_on_inhibited_out <= (state_next == `DSC_ST_INHIBIT);
         jog_active_out <= (state_next == `DSC_ST_RUN) && (owner_next != `DSC_OWN_ON);
         master_control_flag_out <= pc_master_in;
         selected_drive_set_status_out <= dds_status;
         // Drive set switches over only while pulses are off
         if ((state_next == `DSC_ST_INHIBIT) || (state_next == `DSC_ST_READY))
            effective_drive_set_display_out <= ({1'b0, dds_sel} < drive_set_count_in) ?
                                               dds_sel : `DSC_RST_SET;
         effective_command_set_display_out <= cds_eff;
      end
   end

endmodule // dsc_stop_logic

// ---- logic/dsc_consts.vh ----
`ifndef DSC_CONSTS_VH
`define DSC_CONSTS_VH

// Source selector: one code per signal of the source pool
`define DSC_SEL_W 4
`define DSC_SEL_ZERO 4'h0
`define DSC_SEL_ONE 4'h1
`define DSC_SEL_CW_BASE 4'h2
`define DSC_SEL_DI_BASE 4'ha
`define DSC_CMD_N 9
`define DSC_SET_N 4

// Command index inside the source table
`define DSC_CMD_ON 0
`define DSC_CMD_COAST_A 1
`define DSC_CMD_COAST_B 2
`define DSC_CMD_QUICK_A 3
`define DSC_CMD_QUICK_B 4
`define DSC_CMD_JOG1 5
`define DSC_CMD_JOG2 6
`define DSC_CMD_DDS0 7
`define DSC_CMD_DDS1 8

// Control word 1 bit positions
`define DSC_CW_ON_BIT 0
`define DSC_CW_COAST_BIT 1
`define DSC_CW_QUICK_BIT 2

// Control modes
`define DSC_MODE_SPEED 5'h14
`define DSC_MODE_TORQUE 5'h16

// Sequencer states
`define DSC_ST_INHIBIT 3'h0
`define DSC_ST_READY 3'h1
`define DSC_ST_RUN 3'h2
`define DSC_ST_RAMP 3'h3
`define DSC_ST_QUICK 3'h4
`define DSC_ST_WAIT 3'h5

// Owner of the switch-on
`define DSC_OWN_ON 2'h0
`define DSC_OWN_JOG1 2'h1
`define DSC_OWN_JOG2 2'h2

// Reset values
`define DSC_RST_STATE `DSC_ST_INHIBIT
`define DSC_RST_OWNER `DSC_OWN_ON
`define DSC_RST_SET 2'h0
`define DSC_RST_CNT 16'h0000

`endif

// ---- testbench/dsc_fieldbus_model.sv ----
// ----------------------------------------
// Fieldbus controller seen by the drive
// ----------------------------------------
module dsc_fieldbus_model
(
   input wire logic core_clk_in,
   input wire logic [7:0] cmd_in,
   output wire logic [15:0] control_word_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Upper control word bits are never selectable, so they churn to expose decode slips
   logic [7:0] noise_reg = 8'h00;
   always @(negedge core_clk_in) noise_reg <= 8'($urandom);
   assign control_word_out = {noise_reg, cmd_in};
endmodule // dsc_fieldbus_model

// ---- testbench/dsc_stop_logic_asserts.sv ----
// ----------------------------------------
// Stop sequencing checks
// ----------------------------------------
module dsc_stop_logic_chk
(
   input wire core_clk_in,
   input wire reset_in,
   input wire pc_master_in,
   input wire [2:0] pc_control_word_in,
   input wire [1:0] command_set_select_in,
   input wire [2:0] command_set_count_in,
   input wire [2:0] drive_set_count_in,
   input wire pulse_enable_out,
   input wire ramp_stop_brake_out,
   input wire quick_stop_brake_out,
   input wire switch_on_inhibited_out,
   input wire jog_active_out,
   input wire master_control_flag_out,
   input wire [1:0] selected_drive_set_status_out,
   input wire [1:0] effective_command_set_display_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   inhibit_no_pulse_a: assert property (switch_on_inhibited_out |-> !pulse_enable_out)
      else $error("pulses enabled while inhibited");
   brakes_exclusive_a: assert property (!(ramp_stop_brake_out && quick_stop_brake_out))
      else $error("both brake ramps active");
   quick_pulses_a: assert property (quick_stop_brake_out |-> pulse_enable_out)
      else $error("quick ramp without pulses");
   ramp_from_run_a: assert property ($rose(ramp_stop_brake_out) |-> $past(pulse_enable_out))
      else $error("ramp started without running");
   enable_after_ack_a: assert property ($rose(pulse_enable_out) |-> !$past(switch_on_inhibited_out))
      else $error("switched on straight from inhibited");
   pc_coast_a: assert property (pc_master_in && !pc_control_word_in[1] |=>
      switch_on_inhibited_out && !pulse_enable_out) else $error("pc coast stop missed");
   master_copy_a: assert property (master_control_flag_out == $past(pc_master_in))
      else $error("master flag wrong");
   single_set_a: assert property (drive_set_count_in <= 3'h1 |=>
      selected_drive_set_status_out == 2'h0) else $error("single set status not zero");
   cmd_set_a: assert property (command_set_select_in < command_set_count_in |=>
      effective_command_set_display_out == $past(command_set_select_in))
      else $error("command set display wrong");
   jog_runs_a: assert property (jog_active_out |-> pulse_enable_out)
      else $error("jog without pulses");
   cover property (quick_stop_brake_out);
   cover property (jog_active_out);
   cover property ($fell(pulse_enable_out) && pc_master_in);
endmodule // dsc_stop_logic_chk

bind dsc_stop_logic dsc_stop_logic_chk chk_u (.*);

// ---- testbench/tb_top.sv ----
// ----------------------------------------
// Stop command sequencing bench
// ----------------------------------------
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in = 0, reset_in = 1, pc_master_in = 0, torque_mode_switch_in = 0;
   logic [7:0] cmd = 8'h16;
   logic [2:0] pc_control_word_in = 3'h6, command_set_count_in = 3'h1, drive_set_count_in = 3'h1;
   logic [1:0] command_set_select_in = 2'h0;
   logic [5:0] digital_in = 6'h00;
   logic [4:0] control_mode_select_in = 5'h14;
   logic [15:0] speed_abs_in = 16'h0100, standstill_threshold_in = 16'h0010;
   logic [15:0] standstill_monitor_time_in = 16'h0003, on_ramp_stop_source_in = 16'h2222;
   logic [15:0] coast_stop_source_a_in = 16'h3333, coast_stop_source_b_in = 16'h6666;
   logic [15:0] quick_stop_source_a_in = 16'h4444, quick_stop_source_b_in = 16'h1111;
   // Second jog listens to pin 5, so the pin filter path is exercised
   logic [15:0] jog_source_one_in = 16'h5555, jog_source_two_in = 16'hffff;
   // Bit 0 in sets 2 and 3 picks the constants, so the effective set shows in the status
   logic [15:0] drive_set_select_bit0_source_in = 16'h1077;
   logic [15:0] drive_set_select_bit1_source_in = 16'h8888;
   wire [15:0] control_word_in;
   wire pulse_enable_out, ramp_stop_brake_out, quick_stop_brake_out, switch_on_inhibited_out;
   wire jog_active_out, master_control_flag_out;
   wire [1:0] selected_drive_set_status_out, effective_drive_set_display_out;
   wire [1:0] effective_command_set_display_out;
   int fails = 0, check_count = 0, i;
   logic [31:0] r;
   logic [1:0] cs, ds;
   dsc_fieldbus_model bus_u (.core_clk_in(core_clk_in), .cmd_in(cmd),
      .control_word_out(control_word_in));
   dsc_stop_logic dut_u (.*);
   always #25 core_clk_in = ~core_clk_in;
   task automatic chk(input logic g, input logic e);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED t=%0t flag got %b exp %b", $time, g, e);
      end
   endtask
   task automatic chkv(input logic [1:0] g, input logic [1:0] e);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED t=%0t set got %h exp %h", $time, g, e);
      end
   endtask
   function automatic logic [1:0] exp_status(input logic [2:0] n, input logic [1:0] s);
      return (n <= 3'h1) ? 2'h0 : s;
   endfunction
   function automatic logic [1:0] exp_cset(input logic [1:0] s, input logic [2:0] n);
      return ({1'b0, s} >= n) ? 2'h0 : s;
   endfunction
   function automatic logic exp_bit0(input logic [1:0] c, input logic b);
      return (c == 2'h2) ? 1'b0 : ((c == 2'h3) ? 1'b1 : b);
   endfunction
   function automatic logic [1:0] exp_dset(input logic [2:0] n, input logic [1:0] s);
      return ({1'b0, s} < n) ? s : 2'h0;
   endfunction
   // Bench lives on falling edges; the design samples in between
   task automatic step(input logic [7:0] c);
      cmd = c;
      @(negedge core_clk_in);
   endtask
   task automatic go;
      step(8'h16);
      chk(switch_on_inhibited_out, 1'b0);
      step(8'h17);
      chk(pulse_enable_out, 1'b1);
   endtask
   // Standstill needs several cycles below threshold, so wait bounded
   task automatic settle;
      speed_abs_in = 16'h0000;
      for (int k = 0; k < 20 && switch_on_inhibited_out !== 1'b1; k++) @(negedge core_clk_in);
      chk(switch_on_inhibited_out, 1'b1);
      chk(pulse_enable_out, 1'b0);
      speed_abs_in = 16'h0100;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #2000000;
      fails++;
      end_of_test;
   end
   initial
   begin
      void'($urandom(26898));
      repeat (3) @(negedge core_clk_in);
      reset_in = 0;
      chk(switch_on_inhibited_out, 1'b1);
      go;
      step(8'h16);
      chk(ramp_stop_brake_out, 1'b1);
      settle;
      $display("test ramp stop done");
      control_mode_select_in = 5'h16;
      go;
      step(8'h16);
      chk(pulse_enable_out, 1'b0);
      chk(ramp_stop_brake_out, 1'b0);
      control_mode_select_in = 5'h14;
      torque_mode_switch_in = 1;
      go;
      step(8'h16);
      chk(ramp_stop_brake_out, 1'b0);
      chk(pulse_enable_out, 1'b1);
      settle;
      go;
      step(8'h13);
      chk(quick_stop_brake_out, 1'b0);
      chk(pulse_enable_out, 1'b1);
      settle;
      torque_mode_switch_in = 0;
      go;
      step(8'h13);
      chk(quick_stop_brake_out, 1'b1);
      settle;
      go;
      quick_stop_source_b_in = 16'h0000;
      step(8'h17);
      chk(quick_stop_brake_out, 1'b1);
      settle;
      quick_stop_source_b_in = 16'h1111;
      $display("test torque and quick stop done");
      go;
      step(8'h11);
      chk(switch_on_inhibited_out, 1'b1);
      chk(quick_stop_brake_out, 1'b0);
      go;
      step(8'h07);
      chk(pulse_enable_out, 1'b0);
      step(8'h16);
      step(8'h1e);
      chk(jog_active_out, 1'b1);
      step(8'h1f);
      step(8'h1e);
      chk(pulse_enable_out, 1'b1);
      chk(ramp_stop_brake_out, 1'b0);
      step(8'h16);
      chk(ramp_stop_brake_out, 1'b1);
      settle;
      $display("test coast and jog done");
      pc_master_in = 1;
      step(8'h16);
      chk(master_control_flag_out, 1'b1);
      pc_control_word_in = 3'h7;
      step(8'h10);
      chk(pulse_enable_out, 1'b1);
      step(8'h00);
      chk(pulse_enable_out, 1'b0);
      pc_control_word_in = 3'h6;
      step(8'h10);
      chk(switch_on_inhibited_out, 1'b0);
      pc_control_word_in = 3'h7;
      step(8'h10);
      chk(pulse_enable_out, 1'b1);
      pc_control_word_in = 3'h5;
      step(8'h16);
      chk(switch_on_inhibited_out, 1'b1);
      pc_master_in = 0;
      step(8'h16);
      chk(master_control_flag_out, 1'b0);
      on_ramp_stop_source_in = 16'h1111;
      step(8'h16);
      chk(pulse_enable_out, 1'b0);
      on_ramp_stop_source_in = 16'h2222;
      $display("test master control done");
      // Pin changes need the synchroniser and filter, so wait bounded
      digital_in = 6'h20;
      for (int k = 0; k < 8 && jog_active_out !== 1'b1; k++) @(negedge core_clk_in);
      chk(jog_active_out, 1'b1);
      digital_in = 6'h00;
      for (int k = 0; k < 8 && ramp_stop_brake_out !== 1'b1; k++) @(negedge core_clk_in);
      chk(ramp_stop_brake_out, 1'b1);
      settle;
      $display("test pin jog done");
      for (i = 0; i < 24; i++)
      begin
         r = $urandom;
         drive_set_count_in = r[4:2];
         command_set_count_in = {1'b0, r[6:5]} + 3'h1;
         command_set_select_in = r[9:8];
         cs = exp_cset(r[9:8], command_set_count_in);
         ds = {r[1], exp_bit0(cs, r[0])};
         step(8'h16 | {1'b0, r[1:0], 5'h00});
         chkv(selected_drive_set_status_out, exp_status(r[4:2], ds));
         chkv(effective_command_set_display_out, cs);
         chkv(effective_drive_set_display_out, exp_dset(r[4:2], ds));
      end
      $display("test data set selection done");
      end_of_test;
   end
endmodule // tb_top
